// ==== rtl/ddrsp_pkg.sv ====
package ddrsp_pkg;
    // data path and array shape
    localparam int DATA_W = 36;
    localparam int ADDR_W = 21;
    localparam int BEATS = 4;
    localparam int BEAT_W = 2;
    localparam int LANE_W = 9;
    localparam int NIBBLE_W = 4;
    localparam int NIB_MASK_W = 2;
    localparam int BYTE_MASK_W = 4;
    localparam int SUB_ARRAYS = 4;
    // simulation-sized array: only the low index bits select a word
    localparam int MEM_IDX_W = 10;
    localparam int MEM_DEPTH = 1 << MEM_IDX_W;

    // address width per configuration
    localparam int ADDR_W_X8 = 21;
    localparam int ADDR_W_X9 = 21;
    localparam int ADDR_W_X18 = 20;
    localparam int ADDR_W_X36 = 19;
    localparam logic [ADDR_W-1:0] ADDR_MASK_X8 =
        ADDR_W'((1 << ADDR_W_X8) - 1);
    localparam logic [ADDR_W-1:0] ADDR_MASK_X9 =
        ADDR_W'((1 << ADDR_W_X9) - 1);
    localparam logic [ADDR_W-1:0] ADDR_MASK_X18 =
        ADDR_W'((1 << ADDR_W_X18) - 1);
    localparam logic [ADDR_W-1:0] ADDR_MASK_X36 =
        ADDR_W'((1 << ADDR_W_X36) - 1);

    // read latency in beats (one beat is one pclk cycle, half a k period)
    localparam int CLK_PERIOD_NS = 8;
    localparam logic [1:0] LAT_LOOP_BEATS = 2'h3;
    localparam logic [1:0] LAT_NOLOOP_BEATS = 2'h2;

    // apb register map
    localparam int PADDR_W = 12;
    localparam logic [PADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [PADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [PADDR_W-1:0] REG_COUNT = 12'h008;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SINGLE_BIT = 2;
    localparam int ST_RD_BUSY_BIT = 0;
    localparam int ST_WR_BUSY_BIT = 1;
    localparam int ST_LOOP_BIT = 2;
    localparam int ST_WADDR_PEND_BIT = 3;
    localparam int ST_SINGLE_BIT = 4;
    localparam int CNT_W = 16;
    localparam logic CTRL_SINGLE_RESET = 1'b0;

    typedef enum logic [1:0] {
        MODE_X8 = 2'h0,
        MODE_X9 = 2'h1,
        MODE_X18 = 2'h2,
        MODE_X36 = 2'h3
    } ddrsp_mode_t;
    localparam ddrsp_mode_t CTRL_MODE_RESET = MODE_X36;

    typedef enum logic [2:0] {
        RD_IDLE = 3'h1,
        RD_WAIT = 3'h2,
        RD_BURST = 3'h4
    } ddrsp_rd_state_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_BURST = 2'h2
    } ddrsp_wr_state_t;

    // one captured write beat: data and per-bit write enables
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] bit_en;
    } ddrsp_wr_beat_t;
endpackage

// ==== rtl/ddrsp_sram.sv ====
// Behaviour
// - write data up to 36 bits is taken on every beat of a write burst.
// - write select low on a k edge starts a four-beat write burst.
// - while the write port is deselected its data inputs are ignored.
// - in x8 two active-low nibble masks gate bits 3:0 and 7:4 per beat.
// - a nibble whose mask is high on its beat is not written.
// - byte-wide modes sample up to four active-low byte masks per beat.
// - bytes whose mask is inactive keep their stored contents.
// - one shared address bus is sampled on k edges for both ports.
// - four sub-arrays; address is 21, 21, 20 or 19 bits for x8 to x36.
// - the address is ignored for a port that is not selected.
// - read data leaves on every beat, from c/c# or k/k# in single mode.
// - read data outputs are released once the read port goes idle.
// - read data width follows the mode and is driven only in bursts.
// - read select low on a k edge starts a four-beat read burst.
// - accesses start only on k edges, never on k# edges.
// - with loop disable low, read latency drops from 1.5 to 1 k cycle.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module ddrsp_sram (
    input wire logic pclk, // system clock, k edges are every other cycle
    input wire logic presetn, // asynchronous reset, active low
    input wire logic [11:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic write_port_select_n, // write port select, active low
    input wire logic read_port_select_n, // read port select, active low
    input wire logic [20:0] sram_addr, // shared address bus
    input wire logic [35:0] write_data, // write data, one beat a cycle
    input wire logic [1:0] nibble_write_mask_n, // x8 nibble masks
    input wire logic [3:0] byte_write_mask_n, // byte masks, x9/x18/x36
    input wire logic loop_disable_n, // low turns the clock loop off
    output logic [35:0] read_data, // read data, one beat a cycle
    output logic read_data_oe, // high while read data is driven
    output logic echo_strobe, // free running echo, high after k edges
    output logic echo_strobe_n // complement echo
);
    // control and status state
    ddrsp_pkg::ddrsp_mode_t mode_reg;
    logic single_reg;
    logic phase_reg;
    logic echo_reg;
    logic echo_n_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [ddrsp_pkg::CNT_W-1:0] wr_count_reg;
    logic [ddrsp_pkg::CNT_W-1:0] rd_count_reg;

    // write engine
    ddrsp_pkg::ddrsp_wr_state_t wr_state_reg;
    logic [ddrsp_pkg::BEAT_W-1:0] wr_beat_reg;
    ddrsp_pkg::ddrsp_wr_beat_t wr_buf_reg [0:ddrsp_pkg::BEATS-1];
    logic [ddrsp_pkg::MEM_IDX_W-1:0] wr_idx_reg;
    logic wr_addr_pend_reg;
    logic commit_reg;

    // read engine
    ddrsp_pkg::ddrsp_rd_state_t rd_state_reg;
    logic [1:0] rd_wait_reg;
    logic [ddrsp_pkg::BEAT_W-1:0] rd_beat_reg;
    logic [ddrsp_pkg::DATA_W-1:0] rd_buf_reg [0:ddrsp_pkg::BEATS-1];
    logic [ddrsp_pkg::DATA_W-1:0] rd_word [0:ddrsp_pkg::SUB_ARRAYS-1];
    logic [ddrsp_pkg::DATA_W-1:0] q_reg;
    logic oe_reg;

    // per-beat write enables from the masks for the active mode
    function automatic logic [35:0] lane_enable(
        input ddrsp_pkg::ddrsp_mode_t m,
        input logic [1:0] nib_n,
        input logic [3:0] byt_n
    );
        logic [35:0] be;
        be = '0;
        case (m)
            ddrsp_pkg::MODE_X8: begin
                be[0 +: ddrsp_pkg::NIBBLE_W] =
                    {ddrsp_pkg::NIBBLE_W{~nib_n[0]}};
                be[ddrsp_pkg::NIBBLE_W +: ddrsp_pkg::NIBBLE_W] =
                    {ddrsp_pkg::NIBBLE_W{~nib_n[1]}};
            end
            ddrsp_pkg::MODE_X9: begin
                be[0 +: ddrsp_pkg::LANE_W] = {ddrsp_pkg::LANE_W{~byt_n[0]}};
            end
            ddrsp_pkg::MODE_X18: begin
                for (int i = 0; i < 2; i++) begin
                    be[i*ddrsp_pkg::LANE_W +: ddrsp_pkg::LANE_W] =
                        {ddrsp_pkg::LANE_W{~byt_n[i]}};
                end
            end
            default: begin
                for (int i = 0; i < ddrsp_pkg::BYTE_MASK_W; i++) begin
                    be[i*ddrsp_pkg::LANE_W +: ddrsp_pkg::LANE_W] =
                        {ddrsp_pkg::LANE_W{~byt_n[i]}};
                end
            end
        endcase
        return be;
    endfunction

    // decode of beat timing, port selects and address width
    wire k_edge = ~phase_reg;
    wire rd_idle = (rd_state_reg == ddrsp_pkg::RD_IDLE);
    wire wr_idle = (wr_state_reg == ddrsp_pkg::WR_IDLE);
    wire rd_start = k_edge & ~read_port_select_n & rd_idle;
    wire wr_start = k_edge & ~write_port_select_n & wr_idle;
    // a read wins the shared address when both selects fall together
    wire wr_addr_take = (wr_start & ~rd_start) |
                        (k_edge & wr_addr_pend_reg);
    wire wr_capture = wr_start | ~wr_idle;
    // burst end points shared by the sequencers and the commit strobe
    wire wr_last = (wr_beat_reg == 2'(ddrsp_pkg::BEATS - 1));
    wire rd_last = (rd_beat_reg == 2'(ddrsp_pkg::BEATS - 1));
    wire rd_burst = (rd_state_reg == ddrsp_pkg::RD_BURST);
    wire rd_wait_done = (rd_wait_reg == 2'h1);
    // beat 0 lands in slot 0 while the counter still reads idle
    wire [1:0] wr_slot = wr_start ? 2'h0 : wr_beat_reg;
    wire both_start = wr_start & rd_start;
    wire [20:0] addr_mask =
        (mode_reg == ddrsp_pkg::MODE_X8) ? ddrsp_pkg::ADDR_MASK_X8 :
        (mode_reg == ddrsp_pkg::MODE_X9) ? ddrsp_pkg::ADDR_MASK_X9 :
        (mode_reg == ddrsp_pkg::MODE_X18) ? ddrsp_pkg::ADDR_MASK_X18 :
        ddrsp_pkg::ADDR_MASK_X36;
    wire [20:0] addr_used = sram_addr & addr_mask;
    // only the low index bits reach the arrays, so high bits alias
    wire [ddrsp_pkg::MEM_IDX_W-1:0] addr_idx =
        addr_used[ddrsp_pkg::MEM_IDX_W-1:0];
    // masks arrive with each beat and are decoded for the active mode
    wire [35:0] beat_en =
        lane_enable(mode_reg, nibble_write_mask_n, byte_write_mask_n);
    wire [35:0] data_mask = lane_enable(mode_reg, 2'h0, 4'h0);
    // latency is picked at the select edge; the pin may move later
    wire [1:0] lat_beats = loop_disable_n ? ddrsp_pkg::LAT_LOOP_BEATS :
                                            ddrsp_pkg::LAT_NOLOOP_BEATS;

    // beat phase and echo strobes run free from reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 1'b0;
            echo_reg <= 1'b0;
            echo_n_reg <= 1'b1;
        end else begin
            phase_reg <= ~phase_reg;
            echo_reg <= k_edge;
            echo_n_reg <= phase_reg;
        end
    end

    // write beats are captured only inside a burst, so idle data is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_state_reg <= ddrsp_pkg::WR_IDLE;
            wr_beat_reg <= '0;
            commit_reg <= 1'b0;
        end else begin
            commit_reg <= wr_capture & wr_last;
            if (wr_start) begin
                wr_state_reg <= ddrsp_pkg::WR_BURST;
                wr_beat_reg <= 2'h1;
            end else if (!wr_idle) begin
                wr_beat_reg <= wr_beat_reg + 2'h1;
                if (wr_last) begin
                    wr_state_reg <= ddrsp_pkg::WR_IDLE;
                end
            end
        end
    end

    // beat buffer: data and mask taken on the same edge
    always_ff @(posedge pclk) begin
        if (wr_capture) begin
            wr_buf_reg[wr_slot] <= '{
                data: write_data,
                bit_en: beat_en};
        end
    end

    // a write colliding with a read takes the address on the next k edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_idx_reg <= '0;
            wr_addr_pend_reg <= 1'b0;
        end else begin
            if (wr_addr_take) begin
                wr_idx_reg <= addr_idx;
            end
            if (both_start) begin
                wr_addr_pend_reg <= 1'b1;
            end else if (k_edge) begin
                wr_addr_pend_reg <= 1'b0;
            end
        end
    end

    // four sub-arrays, one per beat of a burst
    generate
        for (genvar g = 0; g < ddrsp_pkg::SUB_ARRAYS; g++) begin : g_sub
            logic [ddrsp_pkg::DATA_W-1:0] sub_mem [0:ddrsp_pkg::MEM_DEPTH-1];
            // masked lanes are merged back from the old word
            always_ff @(posedge pclk) begin
                if (commit_reg) begin
                    sub_mem[wr_idx_reg] <=
                        (sub_mem[wr_idx_reg] & ~wr_buf_reg[g].bit_en) |
                        (wr_buf_reg[g].data & wr_buf_reg[g].bit_en);
                end
            end
            assign rd_word[g] = sub_mem[addr_idx];
        end
    endgenerate

    // the whole burst is fetched at the select edge, then played out
    always_ff @(posedge pclk) begin
        if (rd_start) begin
            for (int i = 0; i < ddrsp_pkg::BEATS; i++) begin
                rd_buf_reg[i] <= rd_word[i];
            end
        end
    end

    // read sequencer: wait out the latency, then four beats
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_state_reg <= ddrsp_pkg::RD_IDLE;
            rd_wait_reg <= '0;
            rd_beat_reg <= '0;
        end else begin
            case (rd_state_reg)
                ddrsp_pkg::RD_IDLE: begin
                    if (rd_start) begin
                        rd_state_reg <= ddrsp_pkg::RD_WAIT;
                        rd_wait_reg <= lat_beats - 2'h1;
                    end
                end
                ddrsp_pkg::RD_WAIT: begin
                    if (rd_wait_done) begin
                        rd_state_reg <= ddrsp_pkg::RD_BURST;
                        rd_beat_reg <= '0;
                    end
                    rd_wait_reg <= rd_wait_reg - 2'h1;
                end
                ddrsp_pkg::RD_BURST: begin
                    rd_beat_reg <= rd_beat_reg + 2'h1;
                    if (rd_last) begin
                        rd_state_reg <= ddrsp_pkg::RD_IDLE;
                    end
                end
                default: begin
                    rd_state_reg <= ddrsp_pkg::RD_IDLE;
                end
            endcase
        end
    end

    // output register; c and k share pclk here, so single clock mode
    // changes only the reference, not the beat timing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_reg <= '0;
            oe_reg <= 1'b0;
        end else if (rd_burst) begin
            q_reg <= rd_buf_reg[rd_beat_reg] & data_mask;
            oe_reg <= 1'b1;
        end else begin
            q_reg <= '0;
            oe_reg <= 1'b0;
        end
    end

    // apb decode
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pready_reg & pwrite;
    // exact word match; sub-word offsets fall into the error path
    wire hit_ctrl = (paddr == ddrsp_pkg::REG_CTRL);
    wire hit_status = (paddr == ddrsp_pkg::REG_STATUS);
    wire hit_count = (paddr == ddrsp_pkg::REG_COUNT);
    wire hit_any = hit_ctrl | hit_status | hit_count;
    // read words; status shows the busy flags and the loop pin live
    wire [31:0] ctrl_word = {29'h0, single_reg, mode_reg};
    wire [31:0] status_word = {27'h0, single_reg, wr_addr_pend_reg,
                               loop_disable_n, ~wr_idle, ~rd_idle};
    wire [31:0] count_word = {rd_count_reg, wr_count_reg};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                         hit_status ? status_word :
                         hit_count ? count_word : 32'h0;
    // only a read setup loads the read mux, so prdata idles at zero
    wire apb_rd_setup = apb_setup & ~pwrite;
    wire ctrl_wr = apb_wr & hit_ctrl & pstrb[0];

    // zero wait state slave: answer registered during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup & ~hit_any;
            prdata_reg <= apb_rd_setup ? rd_mux : 32'h0;
        end
    end

    // mode changes take effect at once; change them only while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= ddrsp_pkg::CTRL_MODE_RESET;
            single_reg <= ddrsp_pkg::CTRL_SINGLE_RESET;
        end else if (ctrl_wr) begin
            mode_reg <= ddrsp_pkg::ddrsp_mode_t'(
                pwdata[ddrsp_pkg::CTRL_MODE_LSB +: 2]);
            single_reg <= pwdata[ddrsp_pkg::CTRL_SINGLE_BIT];
        end
    end

    // burst counters wrap silently
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_count_reg <= '0;
            rd_count_reg <= '0;
        end else begin
            if (commit_reg) begin
                wr_count_reg <= wr_count_reg + 16'h0001;
            end
            if (rd_start) begin
                rd_count_reg <= rd_count_reg + 16'h0001;
            end
        end
    end

    // all outputs straight from flip-flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign read_data = q_reg;
    assign read_data_oe = oe_reg;
    assign echo_strobe = echo_reg;
    assign echo_strobe_n = echo_n_reg;
endmodule // ddrsp_sram

// ==== tb/ddrsp_host.sv ====
`timescale 1ns/100ps
module ddrsp_host (
    input wire logic pclk, // beat clock
    input wire logic presetn, // reset, active low
    input wire logic [35:0] read_data, // beats from the device
    input wire logic read_data_oe, // device drives read data
    output logic write_port_select_n, // write select, active low
    output logic read_port_select_n, // read select, active low
    output logic [20:0] sram_addr, // shared address
    output logic [35:0] write_data, // write beats
    output logic [1:0] nibble_write_mask_n, // x8 masks
    output logic [3:0] byte_write_mask_n // byte masks
);
    logic kph;
    logic wr_busy;
    logic a_own;
    logic [20:0] ad;
    logic [35:0] wd;
    logic [1:0] nm;
    logic [3:0] bm;
    logic [63:0] junk;
    initial begin
        write_port_select_n = 1'b1;
        read_port_select_n = 1'b1;
        wr_busy = 1'b0;
        a_own = 1'b0;
        junk = 64'h0F1E_2D3C_4B5A_6978;
    end
    // k phase mirror: the first edge after reset is a k edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kph <= 1'b0;
        end else begin
            kph <= ~kph;
        end
    end
    // released lines flip every cycle, so stale values never look valid
    always @(posedge pclk) begin
        junk <= ~junk;
    end
    assign sram_addr = a_own ? ad : junk[20:0];
    assign write_data = wr_busy ? wd : junk[56:21];
    assign nibble_write_mask_n = wr_busy ? nm : junk[58:57];
    assign byte_write_mask_n = wr_busy ? bm : junk[62:59];
    // returns just after a non-k edge, so the next edge is a k edge
    task automatic to_k();
        @(posedge pclk);
        while (kph !== 1'b1) @(posedge pclk);
    endtask
    task automatic write_burst(input logic [20:0] a,
        input logic [3:0][35:0] d, input logic [3:0][3:0] b,
        input logic [3:0][1:0] n);
        to_k();
        write_port_select_n <= 1'b0;
        ad <= a;
        a_own <= 1'b1;
        wr_busy <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wd <= d[i];
            bm <= b[i];
            nm <= n[i];
            @(posedge pclk);
            write_port_select_n <= 1'b1;
            a_own <= 1'b0;
        end
        wr_busy <= 1'b0;
    endtask
    task automatic read_burst(input logic [20:0] a,
        output logic [3:0][35:0] q, output int lat);
        to_k();
        lat = -1;
        q = '0;
        read_port_select_n <= 1'b0;
        ad <= a;
        a_own <= 1'b1;
        @(posedge pclk);
        read_port_select_n <= 1'b1;
        a_own <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            @(negedge pclk);
            if (read_data_oe === 1'b1 && lat < 0)
                lat = k;
            if (read_data_oe === 1'b1 && k - lat < 4)
                q[k - lat] = read_data;
        end
        // hand back just after a rising edge so the next drive sits on it
        @(posedge pclk);
    endtask
endmodule // ddrsp_host

// ==== tb/ddrsp_sram_sva.sv ====
`timescale 1ns/100ps
module ddrsp_sram_sva (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic read_port_select_n, // read select
    input wire logic loop_disable_n, // loop disable
    input wire logic [35:0] read_data, // read beats
    input wire logic read_data_oe, // read drive enable
    input wire logic echo_strobe, // echo
    input wire logic echo_strobe_n // complement echo
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // released read pins never show a leftover beat
    a_idle_q_zero: assert property (!read_data_oe |-> read_data == 36'h0)
        else $error("read data not zero while released");
    a_burst_four: assert property ($rose(read_data_oe) |-> read_data_oe [*4] ##1 !read_data_oe)
        else $error("read burst not four beats");
    // latency is counted from the select edge, loop state picks 3 or 2
    a_rd_latency: assert property ($rose(read_data_oe) |-> (loop_disable_n && !$past(read_port_select_n, 4)) || (!loop_disable_n && !$past(read_port_select_n, 3)))
        else $error("read data launched at wrong latency");
    a_echo_fall: assert property (echo_strobe |=> !echo_strobe)
        else $error("echo did not fall");
    a_echo_rise: assert property (!echo_strobe |=> echo_strobe)
        else $error("echo did not rise");
    a_echo_pair: assert property (echo_strobe_n == !echo_strobe)
        else $error("echo strobes not complementary");
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    c_rd_loop: cover property ($rose(read_data_oe) && loop_disable_n);
    c_rd_noloop: cover property ($rose(read_data_oe) && !loop_disable_n);
    c_apb_err: cover property (pslverr);
endmodule // ddrsp_sram_sva
bind ddrsp_sram ddrsp_sram_sva chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .read_port_select_n(read_port_select_n),
    .loop_disable_n(loop_disable_n), .read_data(read_data),
    .read_data_oe(read_data_oe), .echo_strobe(echo_strobe),
    .echo_strobe_n(echo_strobe_n));

// ==== tb/ddrsp_sram_tb.sv ====
`timescale 1ns/100ps
module ddrsp_sram_tb;
    logic pclk, presetn, psel, penable, pwrite, ldn, wps_n, rps_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, er, oe;
    logic [20:0] addr;
    logic [35:0] wdat, q_pin, m;
    logic [1:0] nwm;
    logic [3:0] bwm, strb;
    logic [3:0][35:0] d, e, f, q;
    logic [3:0][3:0] bm;
    logic [3:0][1:0] nm;
    int fails, n_compared, lat;
    ddrsp_sram dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .write_port_select_n(wps_n), .read_port_select_n(rps_n),
        .sram_addr(addr), .write_data(wdat), .nibble_write_mask_n(nwm),
        .byte_write_mask_n(bwm), .loop_disable_n(ldn), .read_data(q_pin),
        .read_data_oe(oe), .echo_strobe(), .echo_strobe_n());
    ddrsp_host host_u (.pclk(pclk), .presetn(presetn), .read_data(q_pin),
        .read_data_oe(oe), .write_port_select_n(wps_n),
        .read_port_select_n(rps_n), .sram_addr(addr), .write_data(wdat),
        .nibble_write_mask_n(nwm), .byte_write_mask_n(bwm));
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one zero-wait apb transfer, bounded wait for ready
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] r, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            tally_and_finish();
        end
    endtask
    // written lanes of one beat: byte lanes, or nibbles in x8
    function automatic logic [35:0] lanes(input logic x8,
        input logic [3:0] b, input logic [1:0] n);
        logic [35:0] r;
        r = 36'h0;
        for (int j = 0; j < 4; j++)
            if (!x8 && !b[j]) r[9*j +: 9] = 9'h1FF;
        for (int j = 0; j < 2; j++)
            if (x8 && !n[j]) r[4*j +: 4] = 4'hF;
        return r;
    endfunction
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        ldn = 1'b1;
        strb = 4'hF;
        fails = 0;
        n_compared = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and an unmapped offset
        apb(1'b0, 12'h000, 32'h0, rd, er);
        check(36'(rd), 36'h3);
        apb(1'b0, 12'h004, 32'h0, rd, er);
        check(36'(rd), 36'h4);
        apb(1'b0, 12'h00C, 32'h0, rd, er);
        check({35'h0, er}, 36'h1);
        // a control write without byte strobe 0 is dropped
        strb <= 4'hE;
        apb(1'b1, 12'h000, 32'h0, rd, er);
        strb <= 4'hF;
        apb(1'b0, 12'h000, 32'h0, rd, er);
        check(36'(rd), 36'h3);
        // full x36 burst, loop on: latency three beats
        d = {36'h9_1234_5678, 36'hA_5A5A_5A5A, 36'hF_0F0F_0F0F, 36'h3_C3C3_C3C3};
        host_u.write_burst(21'h00055, d, '0, '1);
        host_u.read_burst(21'h00055, q, lat);
        check(36'(lat), 36'h3);
        for (int i = 0; i < 4; i++) check(q[i], d[i]);
        // masked bytes keep old content; loop off shortens latency
        e = ~d;
        bm = {4'h0, 4'hF, 4'h5, 4'hE};
        host_u.write_burst(21'h00055, e, bm, '1);
        ldn <= 1'b0;
        host_u.read_burst(21'h00055, q, lat);
        check(36'(lat), 36'h2);
        for (int i = 0; i < 4; i++) begin
            m = lanes(1'b0, bm[i], 2'h3);
            check(q[i], (e[i] & m) | (d[i] & ~m));
        end
        // x8: nibble masks decide, byte masks held inactive
        ldn <= 1'b1;
        apb(1'b1, 12'h000, 32'h0, rd, er);
        host_u.write_burst(21'h12345, d, '1, '0);
        nm = {2'h3, 2'h2, 2'h1, 2'h0};
        host_u.write_burst(21'h12345, e, '1, nm);
        host_u.read_burst(21'h12345, q, lat);
        for (int i = 0; i < 4; i++) begin
            m = lanes(1'b1, 4'hF, nm[i]);
            check(q[i], ((e[i] & m) | (d[i] & ~m)) & 36'hFF);
        end
        // counters: four write bursts and three reads so far
        apb(1'b0, 12'h008, 32'h0, rd, er);
        check(36'(rd), 36'h0_0003_0004);
        // x18 with single clock mode, then x9 over the same words
        apb(1'b1, 12'h000, 32'h6, rd, er);
        apb(1'b0, 12'h004, 32'h0, rd, er);
        check(36'(rd), 36'h14);
        host_u.write_burst(21'h00077, d, '0, '1);
        bm = {4'hE, 4'hD, 4'h2, 4'h1};
        host_u.write_burst(21'h00077, e, bm, '1);
        host_u.read_burst(21'h00077, q, lat);
        check(36'(lat), 36'h3);
        for (int i = 0; i < 4; i++) begin
            m = lanes(1'b0, bm[i], 2'h3);
            f[i] = ((e[i] & m) | (d[i] & ~m)) & 36'h3_FFFF;
            check(q[i], f[i]);
        end
        apb(1'b1, 12'h000, 32'h1, rd, er);
        bm = {4'hF, 4'h0, 4'hF, 4'h0};
        host_u.write_burst(21'h00077, d, bm, '1);
        host_u.read_burst(21'h00077, q, lat);
        for (int i = 0; i < 4; i++) begin
            m = lanes(1'b0, bm[i], 2'h3);
            check(q[i], ((d[i] & m) | (f[i] & ~m)) & 36'h1FF);
        end
        tally_and_finish();
    end
endmodule // ddrsp_sram_tb
